// >>> rtl/dsc_defs.svh
// Purpose: named constants of the drive panel and spin-up control
// Assumes: 100 MHz system clock, 8 Hz internal slow tick
// Notes:   times are kept in seconds, counts derived from them, except the repeat period kept in ticks
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_CLK_HZ        100000000
`define DSC_TICK_HZ       8
`define DSC_STEP_S        5
`define DSC_START_MAX_S   90
`define DSC_HOLD_STEP_S   2
`define DSC_HOLD_RPT_S    3
// ticks between repeated steps while the address key stays held
`define DSC_RPT_TICKS     4
`define DSC_STEP_TICKS    (`DSC_STEP_S * `DSC_TICK_HZ)
`define DSC_START_TICKS   (`DSC_START_MAX_S * `DSC_TICK_HZ)
`define DSC_HOLD1_TICKS   (`DSC_HOLD_STEP_S * `DSC_TICK_HZ)
`define DSC_HOLD2_TICKS   (`DSC_HOLD_RPT_S * `DSC_TICK_HZ)
`define DSC_HOLD_TOP      5'h1F
`define DSC_ADDR_RST      4'h0
`define DSC_PRE_W         24
`define DSC_TCNT_W        10
`endif

// >>> rtl/dsc_panel.sv
// Purpose: panel keys, lamps and spin-up sequencing of a disk drive
// Assumes: keys are debounced levels, high while pressed
// Notes:   non-volatile values are loaded in the first cycle after reset
// Operation
// - spin-up waits five seconds times the logical address
// - delay runs from zero to seventy-five seconds in equal steps
// - address shown in binary on four lamps, kept across power loss
// - holding address key two seconds steps once, past three repeats
// - selection lamp follows controller selection
// - ready lamp flashes fast while starting, steady on when ready
// - ready lamp flashes slow while stopping, then stays off
// - start key release starts a stopped drive, next one stops it
// - start/stop key state kept across power loss
// - start must finish within ninety seconds, else a fault
// - fast flashing begins only after the address delay expires
// - fault lamp cleared by key, power or host reset once fault gone
// - writes refused while write-protect lamp is lit
// - each write-protect key press toggles protection unless the board override is on
// - write-protect selection kept across power loss
// - board override to protect makes the protect key ineffective
// - remote spin-up and spin-down commands run start or stop cycles
// - single-bank local option starts at power-on with no delay
// - spin-down only in remote, spin-up only with dc power present
// - spin-up command follows the same sequence as the start key
`include "dsc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dsc_panel #(
  parameter int unsigned TICK_CYCLES = `DSC_CLK_HZ / `DSC_TICK_HZ
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       addr_key,
  input  wire logic       start_key,
  input  wire logic       fault_clr_key,
  input  wire logic       wp_key,
  input  wire logic       wp_override,
  input  wire logic       selected,
  input  wire logic       fault_present,
  input  wire logic       motor_ready,
  input  wire logic       motor_stopped,
  input  wire logic       remote_mode,
  input  wire logic       dc_power,
  input  wire logic       single_bank,
  input  wire logic       spin_up_cmd,
  input  wire logic       spin_down_cmd,
  input  wire logic       host_reset_cmd,
  input  wire logic [3:0] nv_addr_in,
  input  wire logic       nv_run_in,
  input  wire logic       nv_wp_in,
  output logic      [3:0] addr_lamp,
  output logic            sel_lamp,
  output logic            ready_lamp,
  output logic            fault_lamp,
  output logic            wp_lamp,
  output logic            write_allow,
  output logic            motor_on,
  output logic      [3:0] nv_addr_out,
  output logic            nv_run_out,
  output logic            nv_wp_out
);
  localparam logic [23:0] PRE_TOP   = 24'(TICK_CYCLES - 1);
  localparam logic [9:0]  STEP_T    = 10'(`DSC_STEP_TICKS);
  localparam logic [9:0]  START_T   = 10'(`DSC_START_TICKS);
  localparam logic [4:0]  HOLD1_T   = 5'(`DSC_HOLD1_TICKS);
  localparam logic [4:0]  HOLD2_T   = 5'(`DSC_HOLD2_TICKS);
  localparam logic [4:0]  RPT_T     = 5'(`DSC_RPT_TICKS);

  dsc_pkg::dsc_regs_t s_q;
  dsc_pkg::dsc_regs_t s_d;
  logic               start_rel;
  logic               clr_rel;
  logic               wp_press;
  logic               start_req;
  logic               stop_req;
  logic               addr_step;
  logic               tmo_evt;
  logic [9:0]         delay_t;
  logic               auto_now;

  // key edges and qualified host commands
  assign start_rel = s_q.start_k & ~start_key;
  assign clr_rel   = s_q.clr_k & ~fault_clr_key;
  assign wp_press  = ~s_q.wp_k & wp_key;
  assign start_req = start_rel | (spin_up_cmd & remote_mode & dc_power);
  assign stop_req  = start_rel | (spin_down_cmd & remote_mode);
  assign delay_t   = 10'(s_q.addr) * STEP_T;
  assign auto_now  = single_bank & ~remote_mode;
  // one step at two seconds of hold, then every repeat period past three
  assign addr_step = s_q.tick & addr_key &
                     ((s_q.hold == HOLD1_T) || (s_q.hold >= HOLD2_T &&
                      5'(s_q.hold - HOLD2_T) % RPT_T == 5'h00));
  assign tmo_evt   = (s_q.st == dsc_pkg::DSC_ST_START) & s_q.tick &
                     (s_q.tcnt == 10'(START_T - 10'h001)) & ~motor_ready;

  // next-state logic
  always_comb
  begin
    s_d         = s_q;
    s_d.start_k = start_key;
    s_d.wp_k    = wp_key;
    s_d.clr_k   = fault_clr_key;
    s_d.sel     = selected;
    s_d.tick    = (s_q.pre == PRE_TOP);
    s_d.pre     = (s_q.pre == PRE_TOP) ? 24'h000000 : s_q.pre + 24'h000001;
    if (s_q.tick)
    begin
      s_d.phase = s_q.phase + 3'h1;
    end
    // address key hold timer wraps inside the repeat window
    if (!addr_key)
    begin
      s_d.hold = 5'h00;
    end
    else if (s_q.tick)
    begin
      s_d.hold = (s_q.hold == `DSC_HOLD_TOP) ? HOLD2_T : s_q.hold + 5'h01;
    end
    if (addr_step)
    begin
      s_d.addr = s_q.addr + 4'h1;
    end
    if (wp_press && !wp_override)
    begin
      s_d.wp = ~s_q.wp;
    end
    // fault clear first so that a new fault in the same cycle wins
    if ((clr_rel || host_reset_cmd) && !fault_present)
    begin
      s_d.fault = 1'b0;
    end
    if (fault_present || tmo_evt)
    begin
      s_d.fault = 1'b1;
    end
    case (s_q.st)
      dsc_pkg::DSC_ST_STOP:
      begin
        if (start_req)
        begin
          s_d.st   = dsc_pkg::DSC_ST_DELAY;
          s_d.run  = 1'b1;
          s_d.tcnt = 10'h000;
        end
      end
      dsc_pkg::DSC_ST_DELAY:
      begin
        if (stop_req)
        begin
          s_d.st  = dsc_pkg::DSC_ST_STOPG;
          s_d.run = 1'b0;
        end
        else if (s_q.tcnt >= delay_t)
        begin
          s_d.st   = dsc_pkg::DSC_ST_START;
          s_d.tcnt = 10'h000;
        end
        else if (s_q.tick)
        begin
          s_d.tcnt = s_q.tcnt + 10'h001;
        end
      end
      dsc_pkg::DSC_ST_START:
      begin
        if (stop_req)
        begin
          s_d.st  = dsc_pkg::DSC_ST_STOPG;
          s_d.run = 1'b0;
        end
        else if (motor_ready && !fault_present)
        begin
          s_d.st = dsc_pkg::DSC_ST_READY;
        end
        else if (s_q.tick && s_q.tcnt != START_T)
        begin
          s_d.tcnt = s_q.tcnt + 10'h001;
        end
      end
      dsc_pkg::DSC_ST_READY:
      begin
        if (stop_req)
        begin
          s_d.st  = dsc_pkg::DSC_ST_STOPG;
          s_d.run = 1'b0;
        end
      end
      dsc_pkg::DSC_ST_STOPG:
      begin
        if (motor_stopped)
        begin
          s_d.st = dsc_pkg::DSC_ST_STOP;
        end
      end
      default:
      begin
        s_d.st = dsc_pkg::DSC_ST_STOP;
      end
    endcase
    // first cycle after reset restores the retained panel settings
    if (!s_q.loaded)
    begin
      s_d.loaded = 1'b1;
      s_d.addr   = nv_addr_in;
      s_d.wp     = nv_wp_in;
      s_d.run    = nv_run_in | auto_now;
      s_d.tcnt   = 10'h000;
      s_d.st     = auto_now ? dsc_pkg::DSC_ST_START :
                   (nv_run_in ? dsc_pkg::DSC_ST_DELAY : dsc_pkg::DSC_ST_STOP);
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s_q         <= '0;
      s_q.st      <= dsc_pkg::DSC_ST_STOP;
      s_q.addr    <= `DSC_ADDR_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // lamps and outputs; fast flash 4 Hz, slow flash 1 Hz
  assign addr_lamp   = s_q.addr;
  assign sel_lamp    = s_q.sel;
  assign fault_lamp  = s_q.fault;
  assign wp_lamp     = s_q.wp | wp_override;
  assign write_allow = ~wp_lamp;
  assign motor_on    = (s_q.st == dsc_pkg::DSC_ST_START) |
                       (s_q.st == dsc_pkg::DSC_ST_READY);
  assign ready_lamp  = (s_q.st == dsc_pkg::DSC_ST_READY) |
                       ((s_q.st == dsc_pkg::DSC_ST_START) & s_q.phase[0]) |
                       ((s_q.st == dsc_pkg::DSC_ST_STOPG) & s_q.phase[2]);
  assign nv_addr_out = s_q.addr;
  assign nv_run_out  = s_q.run;
  assign nv_wp_out   = s_q.wp;

  // checks
  a_delay_expiry: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.loaded && s_q.st == dsc_pkg::DSC_ST_DELAY && !stop_req &&
    s_q.tcnt == 10'(s_q.addr) * STEP_T |=> s_q.st == dsc_pkg::DSC_ST_START)
    else $error("address delay did not end on time");
  a_delay_dark: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.st == dsc_pkg::DSC_ST_DELAY |-> !ready_lamp)
    else $error("ready lamp lit during address delay");
  a_ready_steady: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.st == dsc_pkg::DSC_ST_READY |-> ready_lamp && motor_on)
    else $error("ready lamp not steady when ready");
  a_stopped_dark: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(s_q.st == dsc_pkg::DSC_ST_STOPG) && s_q.loaded |->
    !ready_lamp && !motor_on)
    else $error("ready lamp lit after stop cycle");
  a_sel_follow: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 sel_lamp == $past(selected))
    else $error("selection lamp does not follow selection");
  a_wp_blocks: assert property (@(posedge clk_sys) disable iff (reset)
    write_allow == !(s_q.wp || wp_override))
    else $error("write allowed while protected");
  a_wp_toggle: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.loaded && wp_press && !wp_override |=> s_q.wp != $past(s_q.wp))
    else $error("protect key did not toggle");
  a_wp_locked: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.loaded && wp_override |=> $stable(s_q.wp))
    else $error("protect key acted under override");
  a_fault_set: assert property (@(posedge clk_sys) disable iff (reset)
    fault_present |=> fault_lamp)
    else $error("fault lamp off while fault present");
  a_start_tmo: assert property (@(posedge clk_sys) disable iff (reset)
    tmo_evt |=> fault_lamp)
    else $error("start timeout raised no fault");
  a_fault_clear: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.loaded && (clr_rel || host_reset_cmd) && !fault_present && !tmo_evt |=> !fault_lamp)
    else $error("fault lamp not cleared after fault went");
  a_resume_delay: assert property (@(posedge clk_sys) disable iff (reset)
    !s_q.loaded && nv_run_in && !auto_now |=> s_q.st == dsc_pkg::DSC_ST_DELAY && nv_run_out)
    else $error("retained run state not resumed");
  a_down_local: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.loaded && s_q.st == dsc_pkg::DSC_ST_READY && !remote_mode &&
    !start_rel |=> s_q.st == dsc_pkg::DSC_ST_READY)
    else $error("drive left ready without a stop request");
  a_addr_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    s_q.loaded && addr_step && s_q.addr == 4'hF |=> s_q.addr == 4'h0)
    else $error("address did not wrap to zero");
  c_reach_ready: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(s_q.st == dsc_pkg::DSC_ST_READY));
  c_stop_cycle: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(s_q.st == dsc_pkg::DSC_ST_STOPG));
  c_addr_step: cover property (@(posedge clk_sys) disable iff (reset)
    addr_step);
  c_fault_clr: cover property (@(posedge clk_sys) disable iff (reset)
    $fell(s_q.fault));
  c_delay_stop: cover property (@(posedge clk_sys) disable iff (reset)
    s_q.st == dsc_pkg::DSC_ST_DELAY && stop_req);
endmodule : dsc_panel
`default_nettype wire

// >>> rtl/dsc_pkg.sv
// Purpose: types of the drive panel and spin-up control
// Assumes: constants come from dsc_defs.svh
// Notes:   one-hot state codes
package dsc_pkg;
  typedef enum logic [4:0] {
    DSC_ST_STOP  = 5'h01,
    DSC_ST_DELAY = 5'h02,
    DSC_ST_START = 5'h04,
    DSC_ST_READY = 5'h08,
    DSC_ST_STOPG = 5'h10
  } dsc_state_t;

  typedef struct packed {
    dsc_state_t  st;
    logic [3:0]  addr;
    logic        run;
    logic        wp;
    logic        fault;
    logic        loaded;
    logic        sel;
    logic        tick;
    logic [23:0] pre;
    logic [9:0]  tcnt;
    logic [4:0]  hold;
    logic [2:0]  phase;
    logic        start_k;
    logic        wp_k;
    logic        clr_k;
  } dsc_regs_t;
endpackage : dsc_pkg

// >>> tb/drive_panel_spinup_control_bench.sv
// Purpose: self-checking bench of the panel and spin-up control
// Assumes: tick shortened to 4 clocks, so one second is 32 clocks
// Notes:   inputs driven at rising edges, outputs read at falling edges
`timescale 1ns/100ps
`default_nettype none
// compare at the falling edge, then resume on the next rising edge
`define CHK(g, e) begin @(negedge clk_sys); total_checks++; \
  if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end \
  @(posedge clk_sys); end
`define WAIT(c, n) begin for (int k = 0; k < n && !(c); k++) \
  @(negedge clk_sys); `CHK(c, 1'b1) end
module drive_panel_spinup_control_bench;
  logic clk_sys, reset, addr_key, start_key, fault_clr_key, wp_key;
  logic wp_override, selected, fault_present, motor_ready, motor_stopped;
  logic remote_mode, dc_power, single_bank, spin_up_cmd, spin_down_cmd;
  logic host_reset_cmd, nv_run_in, nv_wp_in, stall;
  logic sel_lamp, ready_lamp, fault_lamp, wp_lamp, write_allow, motor_on;
  logic nv_run_out, nv_wp_out;
  logic [3:0] nv_addr_in, addr_lamp, nv_addr_out;
  int errors = 0;
  int total_checks = 0;
  int t;
  dsc_panel #(.TICK_CYCLES(4)) i_dut (.*);
  dsc_motor_model i_motor (.*);
  // free-running 100 MHz clock
  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // press and release one key: 0 start, 1 fault clear, 2 write protect
  task automatic key(input int w);
    @(posedge clk_sys);
    if (w == 0) start_key <= 1; else if (w == 1) fault_clr_key <= 1;
    else wp_key <= 1;
    cyc(2);
    start_key <= 0; fault_clr_key <= 0; wp_key <= 0;
    cyc(3);
  endtask
  // one-cycle host pulse: 0 spin up, 1 spin down, 2 reset
  task automatic cmd(input int w);
    @(posedge clk_sys);
    spin_up_cmd <= (w == 0); spin_down_cmd <= (w == 1);
    host_reset_cmd <= (w == 2);
    @(posedge clk_sys);
    spin_up_cmd <= 0; spin_down_cmd <= 0; host_reset_cmd <= 0;
    cyc(2);
  endtask
  // count ready lamp changes over n cycles
  task automatic flash(input int n, output int cnt);
    logic p;
    cnt = 0;
    @(negedge clk_sys);
    p = ready_lamp;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (ready_lamp !== p) cnt++;
      p = ready_lamp;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // cuts a hang short
  initial
  begin
    #300000;
    errors++;
    wrap_up;
  end
  initial
  begin
    reset = 1; addr_key = 0; start_key = 0; fault_clr_key = 0; wp_key = 0;
    wp_override = 0; selected = 0; fault_present = 0; remote_mode = 0;
    dc_power = 1; single_bank = 0; spin_up_cmd = 0; spin_down_cmd = 0;
    host_reset_cmd = 0; nv_addr_in = 4'hE; nv_run_in = 0; nv_wp_in = 0;
    stall = 1;
    cyc(2);
    reset <= 0;
    cyc(2);
    @(negedge clk_sys);
    `CHK(addr_lamp, 4'hE)
    `CHK(write_allow, 1'b1)
    // address key held: step after two seconds, then repeat and wrap
    @(posedge clk_sys) addr_key <= 1;
    cyc(56);
    `CHK(addr_lamp, 4'hE)
    `WAIT(addr_lamp === 4'hF, 20)
    `WAIT(addr_lamp === 4'h0, 40)
    `WAIT(addr_lamp === 4'h1, 20)
    `WAIT(addr_lamp === 4'h2, 20)
    @(posedge clk_sys) addr_key <= 0;
    cyc(8);
    `CHK(nv_addr_out, 4'h2)
    // write protect toggles, override freezes the selection
    key(2);
    `CHK({wp_lamp, write_allow, nv_wp_out}, 3'b101)
    key(2);
    `CHK({wp_lamp, write_allow, nv_wp_out}, 3'b010)
    wp_override <= 1;
    key(2);
    `CHK({wp_lamp, write_allow, nv_wp_out}, 3'b100)
    wp_override <= 0;
    // local start: ten seconds at address two, then fast flash
    key(0);
    `CHK(nv_run_out, 1'b1)
    cyc(300);
    `CHK(motor_on, 1'b0)
    `WAIT(motor_on === 1'b1, 40)
    flash(32, t);
    `CHK(t, 8)
    stall <= 0;
    `WAIT(ready_lamp === 1'b1 && motor_ready === 1'b1, 60)
    flash(32, t);
    `CHK({t, ready_lamp}, {32'd0, 1'b1})
    // second release stops with slow flash, then dark
    stall <= 1;
    key(0);
    `CHK(motor_on, 1'b0)
    flash(32, t);
    `CHK(t, 2)
    stall <= 0;
    `WAIT(motor_stopped === 1'b1, 60)
    flash(16, t);
    `CHK({t, ready_lamp, nv_run_out}, {32'd0, 2'b00})
    // host spin commands obey local/remote and dc power
    cmd(0);
    `CHK(motor_on, 1'b0)
    remote_mode <= 1; dc_power <= 0;
    cmd(0);
    `CHK(motor_on, 1'b0)
    dc_power <= 1;
    cmd(0);
    cyc(300);
    `CHK(motor_on, 1'b0)
    `WAIT(motor_on === 1'b1, 40)
    remote_mode <= 0;
    cmd(1);
    `CHK(motor_on, 1'b1)
    remote_mode <= 1;
    cmd(1);
    `CHK(motor_on, 1'b0)
    // fault latch and its clearing paths
    fault_present <= 1;
    key(1);
    `CHK(fault_lamp, 1'b1)
    fault_present <= 0;
    cyc(3);
    `CHK(fault_lamp, 1'b1)
    cmd(2);
    `CHK(fault_lamp, 1'b0)
    fault_present <= 1;
    cyc(3);
    fault_present <= 0;
    key(1);
    `CHK(fault_lamp, 1'b0)
    // selection lamp follows the controller
    selected <= 1;
    cyc(3);
    `CHK(sel_lamp, 1'b1)
    selected <= 0;
    cyc(3);
    `CHK(sel_lamp, 1'b0)
    // retained run state resumes the delay; a release there stops it
    nv_addr_in <= 4'h2; nv_run_in <= 1; nv_wp_in <= 1; reset <= 1;
    cyc(2);
    reset <= 0;
    cyc(3);
    `CHK({motor_on, nv_run_out, wp_lamp, write_allow}, 4'h6)
    `CHK({addr_lamp, nv_wp_out}, 5'h05)
    key(0);
    `CHK({motor_on, nv_run_out, ready_lamp}, 3'h0)
    // single-bank local power-on starts at once; slow spin times out
    remote_mode <= 0; single_bank <= 1; stall <= 1; reset <= 1;
    nv_run_in <= 0;
    cyc(2);
    reset <= 0;
    `WAIT(motor_on === 1'b1, 4)
    cyc(2850);
    `CHK(fault_lamp, 1'b0)
    `WAIT(fault_lamp === 1'b1, 60)
    wrap_up;
  end
endmodule // drive_panel_spinup_control_bench
`default_nettype wire

// >>> tb/dsc_motor_model.sv
// Purpose: spindle and head model facing the spin-up control
// Assumes: motor_on high asks for spin, low asks for stop
// Notes:   stall holds the motor short of ready or short of stopped
`timescale 1ns/100ps
`default_nettype none
module dsc_motor_model (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic motor_on,
  input  wire logic stall,
  output logic      motor_ready,
  output logic      motor_stopped
);
  int unsigned spd;
  // speed ramps up while driven, coasts down otherwise
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      spd <= 0;
    else if (motor_on)
      spd <= (spd < 40) ? spd + 1 : spd;
    else
      spd <= (spd > 0) ? spd - 1 : 0;
  // reports follow the drive's start and stop cycles
  assign motor_ready   = motor_on && spd == 40 && !stall;
  assign motor_stopped = !motor_on && spd == 0 && !stall;
endmodule // dsc_motor_model
`default_nettype wire
